// File: src/cffc_top.sv
/*
  column flat field correction: pixel = gain[col] * (pixel + offset[col]),
  with an AHB-Lite register slave and a user coefficient table.
  assumes pixel stream, factory table, nonvolatile store and camera gain level
  all run on mclk; factory table and store answer as described in the ports.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "cffc_map.svh"
module cffc_top #(
  parameter int PIX_W    = 12,
  parameter int COLS     = 1024,
  parameter int LVL_W    = 4,
  parameter int OFF_STEP = `CFFC_OFF_STEP
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire cffc_pkg::cffc_pix_t   pix_in,
  output cffc_pkg::cffc_pix_t        pix_out,
  input  wire logic [LVL_W-1:0]      gain_level,
  output logic [15:0]                fac_col,
  output logic [LVL_W-1:0]           fac_level,
  input  wire cffc_pkg::cffc_coef_t  fac_coef,
  output cffc_pkg::cffc_nv_req_t     nv_req,
  input  wire cffc_pkg::cffc_coef_t  nv_rdata,
  input  wire logic                  nv_has_copy
);
  localparam int CW = $clog2(COLS);
  localparam logic [32:0] PIX_MAX = 33'((64'd1 << PIX_W) - 64'd1);

  // register file state
  logic                en_reg, en_next;
  cffc_pkg::cffc_src_t mode_reg, mode_next;
  logic [CW-1:0]       colsel_reg, colsel_next;
  logic                steperr_reg, steperr_next;
  logic                accerr_reg, accerr_next;
  logic                dp_act_reg, dp_act_next;
  logic                dp_wr_reg, dp_wr_next;
  logic [7:0]          dp_addr_reg, dp_addr_next;
  logic                hready_reg, hready_next;
  logic [31:0]         hrdata_reg, hrdata_next;
  // table walk state
  cffc_pkg::cffc_walk_t walk_reg, walk_next;
  logic [CW:0]         widx_reg, widx_next;
  logic                ld_pend_reg, ld_pend_next;
  logic [CW-1:0]       ld_idx_reg, ld_idx_next;
  logic                use_nv_reg, use_nv_next;
  cffc_pkg::cffc_nv_req_t nv_reg, nv_next;
  // user table
  logic [15:0]         gain_mem [COLS];
  logic [15:0]         off_mem  [COLS];
  logic                mw_gain, mw_off;
  logic [CW-1:0]       mw_idx;
  cffc_pkg::cffc_coef_t mw_coef;
  // pixel path state
  logic [CW-1:0]       col_reg, col_next;
  cffc_pkg::cffc_pix_t s1_reg, s1_next;
  logic [CW-1:0]       s1_col_reg, s1_col_next;
  logic [LVL_W-1:0]    lvl_reg, lvl_next;
  logic                act_reg, act_next;
  cffc_pkg::cffc_pix_t out_reg, out_next;

  logic calib;
  logic busy;
  logic ap_take;
  assign calib   = (mode_reg == cffc_pkg::CFFC_SRC_CALIB);
  assign busy    = (walk_reg != cffc_pkg::CFFC_W_IDLE);
  assign ap_take = hsel & hready & htrans[1];

  // register read mux; table words read as zero outside calibration
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `CFFC_A_CTRL: begin
        r[`CFFC_CTRL_EN] = en_reg;
        r[`CFFC_CTRL_MHI:`CFFC_CTRL_MLO] = mode_reg;
      end
      `CFFC_A_STATUS: begin
        r[`CFFC_ST_STEPERR] = steperr_reg;
        r[`CFFC_ST_ACCERR]  = accerr_reg;
        r[`CFFC_ST_BUSY]    = busy;
        r[`CFFC_ST_ACTIVE]  = act_reg;
        r[`CFFC_ST_NVCOPY]  = nv_has_copy;
      end
      `CFFC_A_COLSEL: r[CW-1:0] = calib ? colsel_reg : '0;
      `CFFC_A_GAIN:   r[15:0] = calib ? gain_mem[colsel_reg] : 16'h0000;
      `CFFC_A_OFFSET: r[15:0] = calib ? off_mem[colsel_reg] : 16'h0000;
      `CFFC_A_STEP:   r[15:0] = 16'(OFF_STEP);
      default:        r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // bus slave and control registers
  always_comb begin
    logic wr;
    logic tbl;
    wr = dp_act_reg & dp_wr_reg;
    tbl = (dp_addr_reg == `CFFC_A_COLSEL) || (dp_addr_reg == `CFFC_A_GAIN) ||
          (dp_addr_reg == `CFFC_A_OFFSET) || (dp_addr_reg == `CFFC_A_CMD);
    en_next      = en_reg;
    mode_next    = mode_reg;
    colsel_next  = colsel_reg;
    steperr_next = steperr_reg;
    accerr_next  = accerr_reg;
    dp_act_next  = dp_act_reg;
    dp_wr_next   = dp_wr_reg;
    dp_addr_next = dp_addr_reg;
    hready_next  = hready_reg;
    hrdata_next  = hrdata_reg;
    mw_gain      = 1'b0;
    mw_off       = 1'b0;
    mw_idx       = colsel_reg;
    mw_coef      = '{gain: hwdata[15:0], offset: hwdata[15:0]};
    if (dp_act_reg && !dp_wr_reg && !hready_reg) begin
      hrdata_next = rd_mux(dp_addr_reg);
      hready_next = 1'b1;
      dp_act_next = 1'b0;
    end else if (hready_reg) begin
      dp_act_next  = ap_take;
      dp_wr_next   = hwrite;
      dp_addr_next = haddr[7:0];
      hready_next  = !(ap_take && !hwrite);
    end
    if (wr && hready_reg) begin
      case (dp_addr_reg)
        `CFFC_A_CTRL: begin
          if (!calib)
            en_next = hwdata[`CFFC_CTRL_EN];
          if (hwdata[`CFFC_CTRL_MHI:`CFFC_CTRL_MLO] != 2'b11)
            mode_next = cffc_pkg::cffc_src_t'(hwdata[`CFFC_CTRL_MHI:`CFFC_CTRL_MLO]);
        end
        `CFFC_A_STATUS: begin
          if (hwdata[`CFFC_ST_STEPERR])
            steperr_next = 1'b0;
          if (hwdata[`CFFC_ST_ACCERR])
            accerr_next = 1'b0;
        end
        `CFFC_A_COLSEL: if (calib)
          colsel_next = hwdata[CW-1:0];
        `CFFC_A_GAIN: mw_gain = calib && !busy;
        `CFFC_A_OFFSET: begin
          if ((32'(hwdata[15:0]) % OFF_STEP) != 0)
            steperr_next = 1'b1;
          else
            mw_off = calib && !busy;
        end
        default: ;
      endcase
      if (tbl && (!calib || busy))
        accerr_next = 1'b1;
    end
    if (walk_reg == cffc_pkg::CFFC_W_LOAD && (ld_pend_reg || !use_nv_reg) &&
        widx_reg != '0) begin
      mw_gain = 1'b1;
      mw_off  = 1'b1;
      mw_idx  = ld_pend_reg ? ld_idx_reg : widx_reg[CW-1:0] - 1'b1;
      mw_coef = use_nv_reg ? nv_rdata
                           : '{gain: `CFFC_GAIN_ONE, offset: `CFFC_OFF_NONE};
    end
  end

  // table reset and save walks; reset also runs after power-on reset
  always_comb begin
    logic cmd;
    cmd = dp_act_reg & dp_wr_reg & hready_reg & (dp_addr_reg == `CFFC_A_CMD) &
          calib & !busy;
    walk_next    = walk_reg;
    widx_next    = widx_reg;
    use_nv_next  = use_nv_reg;
    ld_pend_next = 1'b0;
    ld_idx_next  = ld_idx_reg;
    nv_next      = '0;
    case (walk_reg)
      cffc_pkg::CFFC_W_IDLE: begin
        widx_next = '0;
        if (cmd && hwdata[`CFFC_CMD_RESET]) begin
          walk_next   = cffc_pkg::CFFC_W_LOAD;
          use_nv_next = nv_has_copy;
        end else if (cmd && hwdata[`CFFC_CMD_SAVE]) begin
          walk_next = cffc_pkg::CFFC_W_SAVE;
        end
      end
      cffc_pkg::CFFC_W_LOAD: begin
        // store data stands one cycle after the registered read request
        ld_pend_next = nv_reg.re;
        ld_idx_next  = nv_reg.addr[CW-1:0];
        if (widx_reg < (CW+1)'(COLS)) begin
          nv_next.re   = use_nv_reg;
          nv_next.addr = 16'(widx_reg);
          widx_next    = widx_reg + 1'b1;
        end else if (!ld_pend_reg && !nv_reg.re) begin
          walk_next = cffc_pkg::CFFC_W_IDLE;
        end
      end
      cffc_pkg::CFFC_W_SAVE: begin
        if (widx_reg < (CW+1)'(COLS)) begin
          nv_next.we   = 1'b1;
          nv_next.addr = 16'(widx_reg);
          nv_next.coef = '{gain: gain_mem[widx_reg[CW-1:0]],
                           offset: off_mem[widx_reg[CW-1:0]]};
          widx_next    = widx_reg + 1'b1;
        end else begin
          walk_next = cffc_pkg::CFFC_W_IDLE;
        end
      end
      default: walk_next = cffc_pkg::CFFC_W_IDLE;
    endcase
  end

  // pixel path: column count, coefficient pick, correction, saturation
  always_comb begin
    logic [CW-1:0]      cur;
    cffc_pkg::cffc_coef_t c;
    logic signed [17:0] sum;
    logic [32:0]        prod;
    logic [32:0]        sh;
    cur         = pix_in.line_start ? '0 : col_reg;
    col_next    = pix_in.valid ? cur + 1'b1 : col_reg;
    s1_next     = pix_in;
    s1_col_next = cur;
    lvl_next    = gain_level;
    act_next    = en_reg && !calib;
    c = (mode_reg == cffc_pkg::CFFC_SRC_FACTORY) ? fac_coef
        : '{gain: gain_mem[s1_col_reg], offset: off_mem[s1_col_reg]};
    sum  = $signed({2'b00, s1_reg.data}) + $signed({{2{c.offset[15]}}, c.offset});
    prod = (sum < 0) ? 33'h0_0000_0000 : 33'(sum[16:0]) * 33'(c.gain);
    sh   = prod >> `CFFC_GAIN_FRAC;
    out_next = s1_reg;
    if (act_reg)
      out_next.data = (sh > PIX_MAX) ? 16'(PIX_MAX) : sh[15:0];
  end

  always_ff @(posedge mclk) begin
    if (mw_gain)
      gain_mem[mw_idx] <= mw_coef.gain;
    if (mw_off)
      off_mem[mw_idx] <= mw_coef.offset;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      en_reg      <= `CFFC_EN_RST;
      mode_reg    <= cffc_pkg::CFFC_SRC_FACTORY;
      colsel_reg  <= '0;
      steperr_reg <= 1'b0;
      accerr_reg  <= 1'b0;
      dp_act_reg  <= 1'b0;
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
      hready_reg  <= 1'b1;
      hrdata_reg  <= 32'h0000_0000;
      walk_reg    <= cffc_pkg::CFFC_W_LOAD;
      widx_reg    <= '0;
      use_nv_reg  <= 1'b0;
      ld_pend_reg <= 1'b0;
      ld_idx_reg  <= '0;
      nv_reg      <= '0;
      col_reg     <= '0;
      s1_reg      <= '0;
      s1_col_reg  <= '0;
      lvl_reg     <= '0;
      act_reg     <= 1'b0;
      out_reg     <= '0;
    end else begin
      en_reg      <= en_next;
      mode_reg    <= mode_next;
      colsel_reg  <= colsel_next;
      steperr_reg <= steperr_next;
      accerr_reg  <= accerr_next;
      dp_act_reg  <= dp_act_next;
      dp_wr_reg   <= dp_wr_next;
      dp_addr_reg <= dp_addr_next;
      hready_reg  <= hready_next;
      hrdata_reg  <= hrdata_next;
      walk_reg    <= walk_next;
      widx_reg    <= widx_next;
      use_nv_reg  <= use_nv_next;
      ld_pend_reg <= ld_pend_next;
      ld_idx_reg  <= ld_idx_next;
      nv_reg      <= nv_next;
      col_reg     <= col_next;
      s1_reg      <= s1_next;
      s1_col_reg  <= s1_col_next;
      lvl_reg     <= lvl_next;
      act_reg     <= act_next;
      out_reg     <= out_next;
    end
  end

  // a write hazard from leaving calibration mid-frame is left to software
  assign hreadyout = hready_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = 1'b0;
  assign pix_out   = out_reg;
  assign fac_col   = 16'(s1_col_reg);
  assign fac_level = lvl_reg;
  assign nv_req    = nv_reg;
endmodule

// File: src/cffc_map.svh
/*
  register offsets, field positions, reset values and fixed constants
  of the column flat field correction block.
  assumes byte addresses on a 32-bit bus, one word per register.
*/
`ifndef CFFC_MAP_SVH
`define CFFC_MAP_SVH
`define CFFC_A_CTRL     8'h00
`define CFFC_A_STATUS   8'h04
`define CFFC_A_COLSEL   8'h08
`define CFFC_A_GAIN     8'h0c
`define CFFC_A_OFFSET   8'h10
`define CFFC_A_CMD      8'h14
`define CFFC_A_STEP     8'h18
`define CFFC_CTRL_EN    0
`define CFFC_CTRL_MLO   1
`define CFFC_CTRL_MHI   2
`define CFFC_ST_STEPERR 0
`define CFFC_ST_ACCERR  1
`define CFFC_ST_BUSY    2
`define CFFC_ST_ACTIVE  3
`define CFFC_ST_NVCOPY  4
`define CFFC_CMD_RESET  0
`define CFFC_CMD_SAVE   1
`define CFFC_EN_RST     1'b1
`define CFFC_GAIN_ONE   16'h4000
`define CFFC_GAIN_FRAC  14
`define CFFC_OFF_NONE   16'h0000
`define CFFC_OFF_STEP   32
`endif

// File: src/cffc_pkg.sv
/*
  types of the column flat field correction block.
  assumes the constants of cffc_map.svh.
*/
package cffc_pkg;
  typedef enum logic [1:0] {
    CFFC_SRC_FACTORY = 2'b00,
    CFFC_SRC_USER    = 2'b01,
    CFFC_SRC_CALIB   = 2'b10
  } cffc_src_t;

  typedef enum logic [1:0] {
    CFFC_W_IDLE = 2'b00,
    CFFC_W_LOAD = 2'b01,
    CFFC_W_SAVE = 2'b10
  } cffc_walk_t;

  typedef struct packed {
    logic        valid;
    logic        line_start;
    logic [15:0] data;
  } cffc_pix_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
  } cffc_coef_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [15:0] addr;
    cffc_coef_t  coef;
  } cffc_nv_req_t;
endpackage

// File: verif/cffc_far.sv
/* far side model: factory coefficient rom and nonvolatile table store.
   assumes the block's mclk and a one-cycle store read latency. */
`timescale 1ns/10ps
module cffc_far (
  input  wire logic                   mclk,
  input  wire logic [15:0]            fac_col,
  input  wire logic [3:0]             fac_level,
  output cffc_pkg::cffc_coef_t        fac_coef,
  input  wire cffc_pkg::cffc_nv_req_t nv_req,
  output cffc_pkg::cffc_coef_t        nv_rdata,
  output logic                        nv_has_copy
);
  cffc_pkg::cffc_coef_t mem [0:255];
  function automatic cffc_pkg::cffc_coef_t fac(input logic [15:0] c, input logic [3:0] l);
    fac.gain   = 16'h3000 + {c[7:0], 8'h00} + {8'h00, l, 4'h0};
    fac.offset = {c[10:0], 5'h00} - 16'h0080;
  endfunction
  assign fac_coef = fac(fac_col, fac_level);
  initial begin
    nv_has_copy = 1'b0;
    nv_rdata = '0;
  end
  // read data only valid one cycle after a read request, garbage otherwise
  always @(posedge mclk) begin
    nv_rdata <= nv_req.re ? mem[nv_req.addr[7:0]] : ~nv_rdata;
    if (nv_req.we) begin
      mem[nv_req.addr[7:0]] <= nv_req.coef;
      nv_has_copy <= 1'b1;
    end
  end
endmodule

// File: verif/cffc_top_asserts.sv
/* checker of bus timing and pixel pipeline of the correction block.
   assumes it is bound into cffc_top. */
`timescale 1ns/10ps
module cffc_top_asserts #(
  parameter int PIX_W = 12
) (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire cffc_pkg::cffc_pix_t pix_in,
  input wire cffc_pkg::cffc_pix_t pix_out,
  input wire logic [15:0]         fac_col
);
  logic take;
  assign take = hsel && hready && htrans[1];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_ZERO: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_PIX_LAT: assert property (pix_in.valid |-> ##2 pix_out.valid)
    else $error("pixel lost");
  AST_PIX_GAP: assert property (!pix_in.valid |-> ##2 !pix_out.valid)
    else $error("spurious pixel");
  AST_LS_LAT: assert property (pix_in.valid && pix_in.line_start |-> ##2 pix_out.line_start)
    else $error("line start lost");
  AST_COL0: assert property (pix_in.valid && pix_in.line_start |=> fac_col == 16'h0000)
    else $error("column not zero at line start");
  AST_COL_INC: assert property (pix_in.valid && !pix_in.line_start && $past(pix_in.valid)
    |=> fac_col == $past(fac_col) + 16'h0001) else $error("column not stepped");
  AST_CLAMP: assert property (pix_out.valid |-> (pix_out.data >> PIX_W) == 0)
    else $error("pixel out of range");
  cover property (take && !hwrite);
  cover property (pix_in.valid && pix_in.line_start);
  cover property (pix_out.valid && pix_out.data == 16'((1 << PIX_W) - 1));
endmodule
bind cffc_top cffc_top_asserts #(.PIX_W(PIX_W)) i_cffc_top_asserts (.mclk, .rst, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .pix_in, .pix_out, .fac_col);

// File: verif/column_flat_field_correction_test.sv
/* self-checking bench of the column correction block.
   assumes cffc_far stands for factory rom and store; hready is hreadyout. */
`timescale 1ns/10ps
module column_flat_field_correction_test;
  localparam int COLS = 8;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, rd_ph = 0, nv_has_copy, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] gain_level = 0, fac_level;
  logic [15:0] fac_col, ug [COLS], uo [COLS];
  cffc_pkg::cffc_pix_t pix_in = '0, pix_out;
  cffc_pkg::cffc_coef_t fac_coef, nv_rdata;
  cffc_pkg::cffc_nv_req_t nv_req;
  int err_total = 0, cmp_count = 0;
  logic [63:0] rd_q [$];
  logic [15:0] px_q [$];
  always #12.5 mclk = ~mclk;
  cffc_top #(.COLS(COLS)) i_cffc_top (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pix_in, .pix_out, .gain_level,
    .fac_col, .fac_level, .fac_coef, .nv_req, .nv_rdata, .nv_has_copy);
  cffc_far u_far (.mclk, .fac_col, .fac_level, .fac_coef, .nv_req, .nv_rdata, .nv_has_copy);
  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bad(input string what, input logic [31:0] e, g);
    err_total++;
    $display("BAD %s exp %h got %h", what, e, g);
  endtask
  task automatic chk_rd(input logic [63:0] n);
    cmp_count++;
    if (((hrdata ^ n[31:0]) & n[63:32]) !== 32'h0) bad("hrdata", n[31:0], hrdata);
    if (hresp !== 1'b0) bad("hresp", 0, hresp);
  endtask
  task automatic chk_px(input logic [15:0] e);
    cmp_count++;
    if (pix_out.data !== e) bad("pix_out", e, pix_out.data);
  endtask
  // monitor: a read completes when hreadyout returns high in its data phase
  always @(posedge mclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      chk_rd(rd_q.pop_front());
      rd_ph = 0;
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_ph = 1;
    if (pix_out.valid === 1'b1) chk_px(px_q.size() ? px_q.pop_front() : 16'hxxxx);
  end
  function automatic logic [15:0] corr(input logic [15:0] p, g, o);
    longint s;
    s = (int'(p) + $signed(o)) * longint'(g) >>> 14;
    return s < 0 ? 16'h0 : s > 4095 ? 16'hfff : 16'(s);
  endfunction
  // read: d is the expected word, m the mask of bits compared
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, m = 0);
    int n = 0;
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) rd_q.push_back({m, d});
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin bad("hready", 1, 0); wrap_up; end
  endtask
  task automatic idle;
    int k = 0;
    do begin bus(0, 8'h04, 0); k++; end while (hrdata[2] !== 1'b0 && k < 100);
    if (k >= 100) begin bad("busy", 0, 1); wrap_up; end
  endtask
  // md: 0 pass through, 1 factory set, 2 user table
  task automatic line(input int md);
    logic [15:0] p;
    cffc_pkg::cffc_coef_t f;
    gain_level <= 4'($urandom);
    repeat (3) @(posedge mclk);
    for (int c = 0; c < COLS; c++) begin
      p = 16'($urandom % 4096);
      f = u_far.fac(16'(c), gain_level);
      pix_in <= '{1'b1, c == 0, p};
      px_q.push_back(md == 0 ? p : md == 1 ? corr(p, f.gain, f.offset) : corr(p, ug[c], uo[c]));
      @(posedge mclk);
    end
    pix_in <= '{1'b0, 1'b0, 16'($urandom)};
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    void'($urandom(97));
    repeat (4) @(posedge mclk);
    rst <= 0;
    idle;
    bus(0, 8'h00, 32'h1, '1);
    bus(0, 8'h18, 32'h20, '1);
    bus(0, 8'h1c, 32'h0, '1);
    line(1);
    line(1);
    bus(1, 8'h08, 32'h3);
    bus(0, 8'h04, 32'ha, '1);
    bus(1, 8'h04, 32'h3);
    bus(1, 8'h00, 32'h3);
    line(0);
    bus(0, 8'h0c, 32'h0, '1);
    bus(1, 8'h00, 32'h5);
    bus(1, 8'h00, 32'h4);
    bus(0, 8'h00, 32'h5, '1);
    line(0);
    for (int c = 0; c < COLS; c++) begin
      ug[c] = 16'h2000 + 16'($urandom % 24576);
      uo[c] = 16'(($urandom % 256) * 32) - 16'h1000;
      bus(1, 8'h08, c);
      bus(1, 8'h0c, {16'h0, ug[c]});
      bus(1, 8'h10, {16'h0, uo[c]});
      bus(0, 8'h0c, {16'h0, ug[c]}, 32'hffff);
    end
    bus(1, 8'h10, 32'h21);
    bus(0, 8'h04, 32'h1, '1);
    bus(0, 8'h10, {16'h0, uo[COLS-1]}, 32'hffff);
    bus(1, 8'h04, 32'h3);
    line(0);
    bus(1, 8'h14, 32'h2);
    idle;
    bus(0, 8'h04, 32'h10, '1);
    bus(1, 8'h08, 32'h0);
    bus(1, 8'h0c, 32'h4000);
    bus(1, 8'h14, 32'h1);
    idle;
    bus(0, 8'h0c, {16'h0, ug[0]}, 32'hffff);
    bus(1, 8'h00, 32'h3);
    line(2);
    bus(1, 8'h00, 32'h2);
    line(0);
    bus(1, 8'h00, 32'h7);
    bus(0, 8'h00, 32'h3, '1);
    wrap_up;
  end
  initial begin
    #500000;
    bad("timeout", 0, 1);
    wrap_up;
  end
endmodule
